// File: src/dpc_interp_dsm.sv
// Interpolator and multi-bit delta-sigma modulator for both channels.
// Assumes osr is already clamped to 1..1024 and div gives cycles per tick minus one.
`timescale 1ns/1ns
module dpc_interp_dsm
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Engine side
  dpc_mod_if.snk   m
);

  typedef struct packed {
    logic [15:0]           div_cnt;
    logic [10:0]           osr_cnt;
    logic [1:0][23:0]      tgt;
    logic [1:0][23:0]      y;
    logic [1:0][20:0]      err;
    logic [1:0][3:0]       dsm;
    logic                  dsm_stb;
    logic                  frame_req;
  } dpc_dsm_s;

  dpc_dsm_s r_r;
  dpc_dsm_s r_nxt;

  always_comb begin
    logic signed [24:0] v;
    logic signed [24:0] step;
    logic signed [4:0]  q;
    v    = '0;
    step = '0;
    q    = '0;
    r_nxt = r_r;
    r_nxt.dsm_stb   = 1'b0;
    r_nxt.frame_req = 1'b0;
    if (m.smp_stb) begin
      r_nxt.tgt = m.smp;
    end
    if (r_r.div_cnt == 16'h0000) begin
      r_nxt.div_cnt = m.div;
      r_nxt.dsm_stb = 1'b1;
      // One new input sample is wanted after osr modulator ticks.
      if (r_r.osr_cnt >= m.osr - 11'h001) begin
        r_nxt.osr_cnt   = 11'h000;
        r_nxt.frame_req = 1'b1;
      end else begin
        r_nxt.osr_cnt = r_r.osr_cnt + 11'h001;
      end
      for (int ch = 0; ch < NCH; ch++) begin
        step = ($signed({r_r.tgt[ch][23], r_r.tgt[ch]}) - $signed({r_r.y[ch][23], r_r.y[ch]}))
               >>> dpc_interp_shift(m.filt);
        r_nxt.y[ch] = 24'(r_r.y[ch] + step[23:0]);
        v = $signed({r_r.y[ch][23], r_r.y[ch]}) + $signed({4'h0, r_r.err[ch]});
        q = 5'(v >>> 20);
        if (q > 5'sd7) begin
          q = 5'sd7;
        end
        r_nxt.dsm[ch] = q[3:0];
        r_nxt.err[ch] = 21'(v - $signed({q, 20'h00000}));
      end
    end else begin
      r_nxt.div_cnt = r_r.div_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign m.dsm       = r_r.dsm;
  assign m.dsm_stb   = r_r.dsm_stb;
  assign m.frame_req = r_r.frame_req;

endmodule

// File: src/dpc_mod_if.sv
// Carrier between the processing engine and the interpolator and modulator.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface dpc_mod_if;
  import dpc_pkg::*;
  logic [1:0][23:0] smp;
  logic             smp_stb;
  dpc_filt_e        filt;
  logic [10:0]      osr;
  logic [15:0]      div;
  logic [1:0][3:0]  dsm;
  logic             dsm_stb;
  logic             frame_req;
  modport src (output smp, smp_stb, filt, osr, div, input dsm, dsm_stb, frame_req);
  modport snk (input smp, smp_stb, filt, osr, div, output dsm, dsm_stb, frame_req);
endinterface

// File: src/dpc_pkg.sv
// Shared constants, types and block lookup of the DAC processing chain.
// Assumes a single 50 MHz clock domain for all users of the package.
package dpc_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int SMP_W     = 24;
  localparam int NCH       = 2;
  localparam int NBQ       = 6;
  localparam int NCOEF     = 36;
  localparam int DSM_W     = 4;
  localparam int CLK_HZ    = 50000000;

  // ****************************************************************
  // Coefficient layout within one channel
  // ****************************************************************
  localparam int BQ_STRIDE = 5;
  localparam int CI_IIR_N0 = 30;
  localparam int CI_IIR_N1 = 31;
  localparam int CI_IIR_D1 = 32;
  localparam int CI_3D     = 33;
  localparam logic [23:0] COEF_UNITY = 24'h7fffff;
  localparam logic [23:0] COEF_ZERO  = 24'h000000;

  // ****************************************************************
  // Volume, oversampling and mute figures
  // ****************************************************************
  localparam int VOL_MIN   = -127;
  localparam int VOL_MAX   = 48;
  localparam int VOL_OFS   = 132;
  localparam int VOL_STEPS = 12;
  localparam int VOL_SHR   = 26;
  localparam logic [11:0][15:0] VOL_MANT = {
    16'hf1a2, 16'he412, 16'hd745, 16'hcb30, 16'hbfc9, 16'hb505,
    16'haadc, 16'ha145, 16'h9838, 16'h8fad, 16'h879c, 16'h8000};
  localparam logic [10:0] OSR_MIN    = 11'h001;
  localparam logic [10:0] OSR_MAX    = 11'h400;
  localparam logic [10:0] AUTOMUTE_N = 11'h400;
  localparam int BEEP_SHR  = 22;
  localparam int COEF_SHR  = 23;
  localparam logic [4:0] DEFAULT_BLOCK = 5'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    FILT_A = 2'b00,
    FILT_B = 2'b01,
    FILT_C = 2'b10
  } dpc_filt_e;

  typedef struct packed {
    dpc_filt_e  filt;
    logic       stereo;
    logic       iir;
    logic [2:0] nbq;
    logic       dynamic_range_compressor;
    logic       d3;
    logic       beep;
  } dpc_cfg_s;

  // Filter C has the smallest shift, so its passband reaches furthest.
  function automatic logic [1:0] dpc_interp_shift(input dpc_filt_e f);
    case (f)
      FILT_B:  return 2'h2;
      FILT_C:  return 2'h1;
      default: return 2'h3;
    endcase
  endfunction

  function automatic dpc_cfg_s dpc_mk(input dpc_filt_e f, input logic st, input logic iir,
                                      input logic [2:0] nbq, input logic dynamic_range_compressor,
                                      input logic d3, input logic bp);
    dpc_cfg_s c;
    c = '{filt: f, stereo: st, iir: iir, nbq: nbq, dynamic_range_compressor: dynamic_range_compressor, d3: d3, beep: bp};
    return c;
  endfunction

  // Unknown block numbers fall back to the default block.
  function automatic dpc_cfg_s dpc_block_cfg(input logic [4:0] blk);
    case (blk)
      5'h02:   return dpc_mk(FILT_A, 1'b1, 1'b1, 3'h6, 1'b1, 1'b0, 1'b0);
      5'h03:   return dpc_mk(FILT_A, 1'b1, 1'b1, 3'h6, 1'b0, 1'b0, 1'b0);
      5'h04:   return dpc_mk(FILT_A, 1'b0, 1'b0, 3'h3, 1'b0, 1'b0, 1'b0);
      5'h05:   return dpc_mk(FILT_A, 1'b0, 1'b1, 3'h6, 1'b1, 1'b0, 1'b0);
      5'h06:   return dpc_mk(FILT_A, 1'b0, 1'b1, 3'h6, 1'b0, 1'b0, 1'b0);
      5'h07:   return dpc_mk(FILT_B, 1'b1, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
      5'h08:   return dpc_mk(FILT_B, 1'b1, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0);
      5'h09:   return dpc_mk(FILT_B, 1'b1, 1'b0, 3'h4, 1'b0, 1'b0, 1'b0);
      5'h0a:   return dpc_mk(FILT_B, 1'b1, 1'b1, 3'h6, 1'b1, 1'b0, 1'b0);
      5'h0b:   return dpc_mk(FILT_B, 1'b1, 1'b1, 3'h6, 1'b0, 1'b0, 1'b0);
      5'h0c:   return dpc_mk(FILT_B, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
      5'h0d:   return dpc_mk(FILT_B, 1'b0, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0);
      5'h0e:   return dpc_mk(FILT_B, 1'b0, 1'b0, 3'h4, 1'b0, 1'b0, 1'b0);
      5'h0f:   return dpc_mk(FILT_B, 1'b0, 1'b1, 3'h6, 1'b1, 1'b0, 1'b0);
      5'h10:   return dpc_mk(FILT_B, 1'b0, 1'b1, 3'h6, 1'b0, 1'b0, 1'b0);
      5'h11:   return dpc_mk(FILT_C, 1'b1, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
      5'h12:   return dpc_mk(FILT_C, 1'b1, 1'b1, 3'h4, 1'b1, 1'b0, 1'b0);
      5'h13:   return dpc_mk(FILT_C, 1'b1, 1'b1, 3'h4, 1'b0, 1'b0, 1'b0);
      5'h14:   return dpc_mk(FILT_C, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
      5'h15:   return dpc_mk(FILT_C, 1'b0, 1'b1, 3'h4, 1'b1, 1'b0, 1'b0);
      5'h16:   return dpc_mk(FILT_C, 1'b0, 1'b1, 3'h4, 1'b0, 1'b0, 1'b0);
      5'h17:   return dpc_mk(FILT_A, 1'b1, 1'b0, 3'h2, 1'b0, 1'b1, 1'b0);
      5'h18:   return dpc_mk(FILT_A, 1'b1, 1'b1, 3'h5, 1'b1, 1'b1, 1'b0);
      5'h19:   return dpc_mk(FILT_A, 1'b1, 1'b1, 3'h5, 1'b1, 1'b1, 1'b1);
      default: return dpc_mk(FILT_A, 1'b1, 1'b0, 3'h3, 1'b0, 1'b0, 1'b0);
    endcase
  endfunction

endpackage

// File: src/dpc_top.sv
// Playback processing chain: block select, filters, effects, volume, modulator.
// Assumes sample, control and coefficient ports come from logic on clk.
//
// Function
// - Stereo streams from 8 to 192 kHz
// - Order: fixed block, DSP, interpolation, modulator
// - Oversampling ratio programmable from 1 to 1024
// - Block picks interpolation filter A, B or C
// - Volume -63.5 to +24 dB plus mute
// - IIR and biquad coefficients fully host writable
// - Blocks 1, 4: three biquads, filter A
// - Blocks 2,10,5,15: six biquads, IIR, compressor
// - Blocks 3,11,6,16: six biquads, IIR only
// - Blocks 7,17,12,20: IIR only, no biquads
// - Blocks 8,13 four biquads compressor; 9,14 without
// - Blocks 18,21 / 19,22: four biquads, IIR, C
// - Block 23: two biquads, 3D, filter A
// - Blocks 24, 25: five biquads, 3D, 25 beeps
// - Sine tone generator and automatic mute present
// - Coefficients 24-bit signed in three bytes
// - Filter C has widest passband, for 192k
`timescale 1ns/1ns
module dpc_top
  import dpc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Sample stream
  input  wire logic        in_valid,
  input  wire logic [23:0] in_left,
  input  wire logic [23:0] in_right,
  output logic             in_ready,
  output logic             frame_req,
  // Configuration
  input  wire logic [4:0]  block_sel,
  input  wire logic [10:0] osr,
  input  wire logic [15:0] mod_div,
  input  wire logic [7:0]  vol_left,
  input  wire logic [7:0]  vol_right,
  input  wire logic        mute_left,
  input  wire logic        mute_right,
  input  wire logic        auto_mute_en,
  input  wire logic        drc_en,
  input  wire logic [23:0] drc_thr,
  input  wire logic        beep_en,
  input  wire logic [23:0] beep_amp,
  input  wire logic [23:0] beep_cos,
  // Coefficient access
  input  wire logic        coef_ch,
  input  wire logic [5:0]  coef_idx,
  input  wire logic [1:0]  coef_byte,
  input  wire logic [7:0]  coef_wdata,
  input  wire logic        coef_we,
  output logic [7:0]       coef_rdata,
  // Status and modulator output
  output logic             auto_muted,
  output logic [1:0]       active_filt,
  output logic [3:0]       dsm_left,
  output logic [3:0]       dsm_right,
  output logic             dsm_stb
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_IIR  = 3'b001,
    S_BQ   = 3'b010,
    S_FX   = 3'b011,
    S_OUT  = 3'b100
  } dpc_state_e;

  typedef struct packed {
    dpc_state_e                   state;
    dpc_cfg_s                     cfg;
    logic [2:0]                   bq_idx;
    logic [1:0][23:0]             x;
    logic [1:0][NCOEF-1:0][23:0]  coef;
    logic [1:0][23:0]             iir_x1;
    logic [1:0][23:0]             iir_y1;
    logic [1:0][NBQ-1:0][23:0]    bx1;
    logic [1:0][NBQ-1:0][23:0]    bx2;
    logic [1:0][NBQ-1:0][23:0]    by1;
    logic [1:0][NBQ-1:0][23:0]    by2;
    logic [23:0]                  bs1;
    logic [23:0]                  bs2;
    logic [10:0]                  zero_cnt;
    logic [1:0][23:0]             out;
    logic                         out_stb;
    logic                         in_ready;
    logic                         muted;
    logic [7:0]                   rdata;
  } dpc_top_s;

  dpc_top_s r_r;
  dpc_top_s r_nxt;

  // ****************************************************************
  // Arithmetic helpers
  // ****************************************************************
  function automatic logic [23:0] sat24(input logic signed [57:0] v);
    if (v > 58'sd8388607) begin
      return 24'h7fffff;
    end else if (v < -58'sd8388608) begin
      return 24'h800000;
    end
    return v[23:0];
  endfunction

  function automatic logic signed [57:0] mul(input logic [23:0] a, input logic [23:0] b);
    return 58'($signed(a) * $signed(b));
  endfunction

  function automatic logic [23:0] vol_apply(input logic [23:0] x, input logic [7:0] code);
    int  c;
    int  q;
    int  rr;
    logic signed [57:0] p;
    c = int'($signed(code));
    if (c < VOL_MIN) begin
      c = VOL_MIN;
    end
    if (c > VOL_MAX) begin
      c = VOL_MAX;
    end
    q  = (c + VOL_OFS) / VOL_STEPS;
    rr = (c + VOL_OFS) % VOL_STEPS;
    p  = 58'($signed(x) * $signed({1'b0, VOL_MANT[rr]}));
    return sat24((p <<< q) >>> VOL_SHR);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic signed [57:0] acc;
    logic [23:0]        ax;
    logic [23:0]        y;
    int                 b;
    acc   = '0;
    ax    = '0;
    y     = '0;
    b     = 0;
    r_nxt = r_r;
    r_nxt.out_stb = 1'b0;
    if (coef_we && (int'(coef_idx) < NCOEF) && coef_byte != 2'h3) begin
      r_nxt.coef[coef_ch][coef_idx][(2 - int'(coef_byte)) * 8 +: 8] = coef_wdata;
    end
    if (int'(coef_idx) < NCOEF && coef_byte != 2'h3) begin
      r_nxt.rdata = r_r.coef[coef_ch][coef_idx][(2 - int'(coef_byte)) * 8 +: 8];
    end else begin
      r_nxt.rdata = 8'h00;
    end
    case (r_r.state)
      S_IDLE: begin
        if (in_valid && r_r.in_ready) begin
          // Block choice is sampled only between samples, never mid-chain.
          r_nxt.cfg   = dpc_block_cfg(block_sel);
          r_nxt.x[0]  = in_left;
          r_nxt.x[1]  = in_right;
          if (in_left == 24'h000000 && in_right == 24'h000000) begin
            if (r_r.zero_cnt != AUTOMUTE_N) begin
              r_nxt.zero_cnt = r_r.zero_cnt + 11'h001;
            end
          end else begin
            r_nxt.zero_cnt = 11'h000;
          end
          r_nxt.state = S_IIR;
        end
      end
      S_IIR: begin
        for (int ch = 0; ch < NCH; ch++) begin
          if (r_r.cfg.iir && (ch == 0 || r_r.cfg.stereo)) begin
            acc = mul(r_r.coef[ch][CI_IIR_N0], r_r.x[ch]) +
                  mul(r_r.coef[ch][CI_IIR_N1], r_r.iir_x1[ch]) +
                  mul(r_r.coef[ch][CI_IIR_D1], r_r.iir_y1[ch]);
            y = sat24(acc >>> COEF_SHR);
            r_nxt.iir_x1[ch] = r_r.x[ch];
            r_nxt.iir_y1[ch] = y;
            r_nxt.x[ch]      = y;
          end
        end
        r_nxt.bq_idx = 3'h0;
        r_nxt.state  = (r_r.cfg.nbq != 3'h0) ? S_BQ : S_FX;
      end
      S_BQ: begin
        b = int'(r_r.bq_idx) * BQ_STRIDE;
        for (int ch = 0; ch < NCH; ch++) begin
          if (ch == 0 || r_r.cfg.stereo) begin
            acc = mul(r_r.coef[ch][b], r_r.x[ch]) +
                  (mul(r_r.coef[ch][b + 1], r_r.bx1[ch][r_r.bq_idx]) <<< 1) +
                  mul(r_r.coef[ch][b + 2], r_r.bx2[ch][r_r.bq_idx]) +
                  (mul(r_r.coef[ch][b + 3], r_r.by1[ch][r_r.bq_idx]) <<< 1) +
                  mul(r_r.coef[ch][b + 4], r_r.by2[ch][r_r.bq_idx]);
            y = sat24(acc >>> COEF_SHR);
            r_nxt.bx2[ch][r_r.bq_idx] = r_r.bx1[ch][r_r.bq_idx];
            r_nxt.bx1[ch][r_r.bq_idx] = r_r.x[ch];
            r_nxt.by2[ch][r_r.bq_idx] = r_r.by1[ch][r_r.bq_idx];
            r_nxt.by1[ch][r_r.bq_idx] = y;
            r_nxt.x[ch]               = y;
          end
        end
        r_nxt.bq_idx = r_r.bq_idx + 3'h1;
        if (r_r.bq_idx + 3'h1 >= r_r.cfg.nbq) begin
          r_nxt.state = S_FX;
        end
      end
      S_FX: begin
        if (r_r.cfg.d3) begin
          ax = 24'($signed(r_r.x[0]) - $signed(r_r.x[1]));
          y  = sat24(mul(r_r.coef[0][CI_3D], ax) >>> COEF_SHR);
          r_nxt.x[0] = sat24(58'($signed(r_r.x[0])) + 58'($signed(y)));
          r_nxt.x[1] = sat24(58'($signed(r_r.x[1])) - 58'($signed(y)));
        end
        for (int ch = 0; ch < NCH; ch++) begin
          if (r_r.cfg.dynamic_range_compressor && drc_en) begin
            ax = r_r.x[ch][23] ? 24'(-$signed(r_r.x[ch])) : r_r.x[ch];
            if (ax > drc_thr) begin
              y = drc_thr + ((ax - drc_thr) >> 2);
              r_nxt.x[ch] = r_r.x[ch][23] ? 24'(-$signed(y)) : y;
            end
          end
        end
        if (r_r.cfg.beep && beep_en) begin
          // Recursive oscillator: next = 2cos(w) * s1 - s2.
          r_nxt.bs1 = sat24((mul(beep_cos, r_r.bs1) >>> BEEP_SHR) - 58'($signed(r_r.bs2)));
          r_nxt.bs2 = r_r.bs1;
          for (int ch = 0; ch < NCH; ch++) begin
            r_nxt.x[ch] = sat24(58'($signed(r_nxt.x[ch])) + 58'($signed(r_r.bs1)));
          end
        end else begin
          r_nxt.bs1 = beep_amp;
          r_nxt.bs2 = 24'h000000;
        end
        r_nxt.state = S_OUT;
      end
      S_OUT: begin
        r_nxt.out[0] = (mute_left || (auto_mute_en && r_r.zero_cnt == AUTOMUTE_N)) ?
                       24'h000000 : vol_apply(r_r.x[0], vol_left);
        r_nxt.out[1] = (mute_right || !r_r.cfg.stereo ||
                        (auto_mute_en && r_r.zero_cnt == AUTOMUTE_N)) ?
                       24'h000000 : vol_apply(r_r.x[1], vol_right);
        r_nxt.out_stb = 1'b1;
        r_nxt.state   = S_IDLE;
      end
      default: begin
        r_nxt.state = S_IDLE;
      end
    endcase
    r_nxt.in_ready = (r_nxt.state == S_IDLE) && !(in_valid && r_r.in_ready);
    r_nxt.muted    = r_nxt.zero_cnt == AUTOMUTE_N;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_r <= '0;
      r_r.cfg <= dpc_block_cfg(DEFAULT_BLOCK);
      for (int ch = 0; ch < NCH; ch++) begin
        for (int k = 0; k < NBQ; k++) begin
          r_r.coef[ch][k * BQ_STRIDE] <= COEF_UNITY;
        end
        r_r.coef[ch][CI_IIR_N0] <= COEF_UNITY;
        r_r.coef[ch][CI_3D]     <= COEF_ZERO;
      end
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************************************
  // Interpolator and modulator
  // ****************************************************************
  dpc_mod_if mif ();

  assign mif.smp     = r_r.out;
  assign mif.smp_stb = r_r.out_stb;
  assign mif.filt    = r_r.cfg.filt;
  assign mif.osr     = (osr == 11'h000) ? OSR_MIN : ((osr > OSR_MAX) ? OSR_MAX : osr);
  assign mif.div     = mod_div;

  dpc_interp_dsm u_dsm (
    .clk    (clk),
    .arst_n (arst_n),
    .m      (mif.snk)
  );

  assign in_ready    = r_r.in_ready;
  assign frame_req   = mif.frame_req;
  assign coef_rdata  = r_r.rdata;
  assign auto_muted  = r_r.muted;
  assign active_filt = r_r.cfg.filt;
  assign dsm_left    = mif.dsm[0];
  assign dsm_right   = mif.dsm[1];
  assign dsm_stb     = mif.dsm_stb;

endmodule

// File: test/dpc_src_model.sv
// Sample source standing in for the serial audio interface.
// Assumes go is a one-cycle pulse from the bench, given only while idle.
`timescale 1ns/1ns
module dpc_src_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        go,
  input  wire logic [15:0] count,
  input  wire logic [23:0] l,
  input  wire logic [23:0] r,
  input  wire logic        in_ready,
  output logic             in_valid,
  output logic [23:0]      in_left,
  output logic [23:0]      in_right,
  output logic             idle
);
  logic [15:0] todo_r;
  logic [15:0] todo_nxt;
  always_comb todo_nxt = go ? count : todo_r - 16'(in_valid && in_ready);
  assign idle = todo_r == 16'h0 && !go;
  // Each pair is held until taken; between bursts the lines invert their data every cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      todo_r   <= 16'h0;
      in_valid <= 1'b0;
      in_left  <= 24'h0;
      in_right <= 24'h0;
    end else begin
      todo_r   <= todo_nxt;
      in_valid <= todo_nxt != 16'h0;
      in_left  <= todo_nxt != 16'h0 ? l : ~in_left;
      in_right <= todo_nxt != 16'h0 ? r : ~in_right;
    end
  end
endmodule

// File: test/dpc_top_assertions.sv
// Port timing checker of the playback chain.
// Assumes it is bound into dpc_top.
`timescale 1ns/1ns
module dpc_chk (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        frame_req,
  input wire logic [15:0] mod_div,
  input wire logic        coef_ch,
  input wire logic [5:0]  coef_idx,
  input wire logic [1:0]  coef_byte,
  input wire logic [7:0]  coef_wdata,
  input wire logic        coef_we,
  input wire logic [7:0]  coef_rdata,
  input wire logic [3:0]  dsm_left,
  input wire logic [3:0]  dsm_right,
  input wire logic        dsm_stb
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_take;
    in_valid && in_ready;
  endsequence
  sequence s_wr;
    coef_we && coef_idx < 6'd36 && coef_byte != 2'h3;
  endsequence
  a_ready_busy: assert property (s_take |=> !in_ready [*3])
    else $error("ready returned early");
  a_ready_back: assert property (s_take |-> ##[4:10] in_ready)
    else $error("ready returned late");
  a_ready_fell: assert property ($fell(in_ready) |-> $past(in_valid) && $past(in_ready))
    else $error("ready fell without a take");
  a_dsm_hold: assert property (!dsm_stb |-> $stable(dsm_left) && $stable(dsm_right))
    else $error("codes moved between ticks");
  a_stb_gap: assert property (dsm_stb && mod_div != 16'h0 |=> !dsm_stb)
    else $error("tick strobe too long");
  a_frame_tick: assert property (frame_req |-> dsm_stb)
    else $error("frame request off tick");
  a_coef_null: assert property (coef_idx > 6'd35 || coef_byte == 2'h3 |=> coef_rdata == 8'h0)
    else $error("unmapped coefficient read");
  a_coef_back: assert property (s_wr ##1 (!coef_we && $stable({coef_ch, coef_idx, coef_byte}))
    ##1 $stable({coef_ch, coef_idx, coef_byte}) |-> coef_rdata == $past(coef_wdata, 2))
    else $error("coefficient readback wrong");
endmodule
bind dpc_top dpc_chk i_chk (.clk, .arst_n, .in_valid, .in_ready, .frame_req, .mod_div,
  .coef_ch, .coef_idx, .coef_byte, .coef_wdata, .coef_we, .coef_rdata, .dsm_left,
  .dsm_right, .dsm_stb);

// File: test/dpc_top_tb.sv
// Self-checking bench of the playback processing chain.
// Assumes the sample source model and the bound port checker.
`timescale 1ns/1ns
module dpc_top_tb;
  logic        clk, arst_n, go, in_valid, in_ready, frame_req, idle, coef_ch, coef_we;
  logic        mute_left, mute_right, auto_mute_en, auto_muted, dsm_stb, drc_en, beep_en;
  logic [1:0]  coef_byte, active_filt;
  logic [3:0]  dsm_left, dsm_right;
  logic [4:0]  block_sel;
  logic [5:0]  coef_idx;
  logic [7:0]  vol_left, vol_right, coef_wdata, coef_rdata;
  logic [10:0] osr;
  logic [15:0] count, mod_div;
  logic [23:0] l, r, in_left, in_right, beep_amp;
  int          bad_count, checked;
  // Filter code in the high nibble, biquad count in the low one, per block.
  localparam logic [7:0] TBL [27] = '{8'h03, 8'h03, 8'h06, 8'h06, 8'h03, 8'h06, 8'h06,
    8'h10, 8'h14, 8'h14, 8'h16, 8'h16, 8'h10, 8'h14, 8'h14, 8'h16, 8'h16, 8'h20,
    8'h24, 8'h24, 8'h20, 8'h24, 8'h24, 8'h02, 8'h05, 8'h05, 8'h03};
  dpc_top i_dut (.clk, .arst_n, .in_valid, .in_left, .in_right, .in_ready, .frame_req,
    .block_sel, .osr, .mod_div, .vol_left, .vol_right, .mute_left, .mute_right,
    .auto_mute_en, .drc_en, .drc_thr(24'h0), .beep_en, .beep_amp,
    .beep_cos(24'h0), .coef_ch, .coef_idx, .coef_byte, .coef_wdata, .coef_we,
    .coef_rdata, .auto_muted, .active_filt, .dsm_left, .dsm_right, .dsm_stb);
  dpc_src_model i_src (.clk, .arst_n, .go, .count, .l, .r, .in_ready, .in_valid,
    .in_left, .in_right, .idle);
  always #10 clk = ~clk;
  task automatic cmp(input string w, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return in_ready;
      1: return idle;
      2: return frame_req;
      default: return !in_ready;
    endcase
  endfunction
  task automatic wt(input int k, input int lim);
    int n;
    n = 0;
    while (pick(k) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        cmp("wait", 24'h0, 24'h1);
        wrap_up();
      end
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [15:0] n, input logic [23:0] a, input logic w);
    @(posedge clk);
    count <= n;
    l <= a;
    r <= a;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    if (w) begin
      wt(1, 9000);
      wt(0, 20);
      tick(2);
    end
  endtask
  task automatic wr(input logic c, input logic [5:0] i, input logic [1:0] b,
                    input logic [7:0] d);
    @(posedge clk);
    coef_ch <= c;
    coef_idx <= i;
    coef_byte <= b;
    coef_wdata <= d;
    coef_we <= 1'b1;
    @(posedge clk);
    coef_we <= 1'b0;
  endtask
  task automatic rd(input logic c, input logic [5:0] i, input logic [1:0] b,
                    input logic [7:0] e);
    @(posedge clk);
    coef_ch <= c;
    coef_idx <= i;
    coef_byte <= b;
    tick(2);
    cmp("coef", 24'(e), 24'(coef_rdata));
  endtask
  task automatic t_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    tick(4);
    cmp("rst_ready", 24'h0, 24'(in_ready));
    cmp("rst_filt", 24'h0, 24'(active_filt));
    cmp("rst_flags", 24'h0, 24'({dsm_stb, frame_req, auto_muted}));
    @(posedge clk);
    arst_n <= 1'b1;
    tick(1);
    cmp("ready_up", 24'h1, 24'(in_ready));
    $display("t_reset done");
  endtask
  task automatic t_blocks;
    int n;
    for (int b = 0; b < 27; b++) begin
      @(posedge clk);
      block_sel <= 5'(b);
      send(16'h1, 24'h100000, 1'b0);
      wt(3, 20);
      n = 0;
      while (in_ready !== 1'b1 && n < 20) begin
        tick(1);
        n++;
      end
      cmp("busy", 24'(TBL[b][3:0]) + 24'h3, 24'(n));
      cmp("filter", 24'(TBL[b][7:4]), 24'(active_filt));
    end
    $display("t_blocks done");
  endtask
  task automatic t_auto;
    @(posedge clk);
    block_sel <= 5'd7;
    auto_mute_en <= 1'b1;
    send(16'd1023, 24'h0, 1'b1);
    cmp("auto_1023", 24'h0, 24'(auto_muted));
    send(16'd1, 24'h0, 1'b1);
    cmp("auto_1024", 24'h1, 24'(auto_muted));
    send(16'd1, 24'h000001, 1'b1);
    cmp("auto_off", 24'h0, 24'(auto_muted));
    auto_mute_en <= 1'b0;
    $display("t_auto done");
  endtask
  task automatic t_mute;
    @(posedge clk);
    block_sel <= 5'd4;
    mute_left <= 1'b1;
    vol_left <= 8'h30;
    vol_right <= 8'h81;
    send(16'd48, 24'h400000, 1'b1);
    tick(40);
    cmp("mute_l", 24'h0, 24'(dsm_left));
    cmp("left_only", 24'h0, 24'(dsm_right));
    mute_left <= 1'b0;
    send(16'd48, 24'h400000, 1'b1);
    tick(40);
    cmp("level", 24'h1, 24'(dsm_left != 4'h0 && !dsm_left[3]));
    @(posedge clk);
    block_sel <= 5'd2;
    {drc_en, vol_left, beep_amp} <= 33'h100400000;
    send(16'd24, 24'h400000, 1'b1);
    cmp("drc", 24'h1, 24'(dsm_left < 4'h3));
    {beep_en, block_sel} <= 6'h39;
    send(16'd1, 24'h0, 1'b1);
    tick(200);
    cmp("beep", 24'h1, 24'(dsm_left > 4'h2 && !dsm_left[3]));
    $display("t_mute done");
  endtask
  task automatic t_coef;
    rd(1'b0, 6'd0, 2'h0, 8'h7f);
    rd(1'b0, 6'd0, 2'h2, 8'hff);
    rd(1'b1, 6'd30, 2'h1, 8'hff);
    rd(1'b1, 6'd31, 2'h0, 8'h00);
    wr(1'b1, 6'd7, 2'h3, 8'hee);
    wr(1'b1, 6'd40, 2'h0, 8'haa);
    for (int i = 0; i < 3; i++) wr(1'b1, 6'd7, 2'(i), 8'h12 + 8'(i * 34));
    for (int i = 0; i < 3; i++) rd(1'b1, 6'd7, 2'(2 - i), 8'h56 - 8'(i * 34));
    rd(1'b0, 6'd7, 2'h0, 8'h00);
    rd(1'b1, 6'd40, 2'h0, 8'h00);
    rd(1'b1, 6'd7, 2'h3, 8'h00);
    $display("t_coef done");
  endtask
  task automatic t_osr;
    int n;
    logic [10:0] v [5] = '{11'd0, 11'd1, 11'd5, 11'd1024, 11'd2000};
    int e [5] = '{4, 4, 20, 4096, 2048};
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      osr <= v[k];
      mod_div <= k == 4 ? 16'd1 : 16'd3;
      wt(2, 5000);
      tick(1);
      wt(2, 5000);
      tick(1);
      n = 1;
      while (frame_req !== 1'b1 && n < 5000) begin
        tick(1);
        n++;
      end
      cmp("frame_gap", 24'(e[k]), 24'(n));
    end
    $display("t_osr done");
  endtask
  initial begin
    {clk, go, coef_ch, coef_we, mute_left, mute_right, auto_mute_en, drc_en, beep_en} = '0;
    {arst_n, coef_byte, coef_idx, coef_wdata, vol_left, vol_right, count, l, r, beep_amp} = '0;
    block_sel = 5'd1;
    osr = 11'd4;
    mod_div = 16'd3;
    t_reset();
    t_blocks();
    t_auto();
    t_mute();
    t_coef();
    t_reset();
    t_osr();
    wrap_up();
  end
endmodule
